//--- logic/adc_serial_readout_interface.sv
// Four-wire serial readout interface of a multiplexed converter
// Notes on behaviour
// - Output changes on falling serial clock, input sampled on rising.
// - Internal mode drives clock as conversion clock divided by eight; external mode inputs it.
// - Clock mode picked at reset release and each chip-select fall from clock level.
// - Data input ignored while chip select high or converting.
// - Chip select low after conversion: output low, then capture input bits.
// - Received channel bits steer the next conversion, not the one read.
// - Data output released while chip select high.
// - Chip select low in convert or sleep: output shows end-of-conversion flag.
// - Data state shifts latest result out, most significant bit first.
// - Sleep lasts until first rising clock edge with chip select low.
// - Chip select rising during data state aborts and starts a conversion.
// - Abort before last address bit keeps the previous channel selection.
// - Chip select held low converts back to back at full rate.
// - Conversion ending with chip select high enters sleep alone.
// - Sleep holds the result in the static shift register.
// - Nineteenth falling edge starts a conversion and drives output high.
// - Result copied to shift register when the flag falls.
// - Frame: flag bit 18, filler bit 17, polarity bit 16, result 15..0.
module adc_serial_readout_interface #(
    parameter int CONV_CYCLES = adc_serial_pkg::CONV_CYCLES,
    parameter int ADDR_BITS = adc_serial_pkg::ADDR_BITS
) (
    // Clock, reset, enable
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    input wire logic I_CE,
    // Conversion clock tick and converter core
    input wire logic I_CONV_TICK,
    input wire logic I_POLARITY_BIT,
    input wire logic [15:0] I_RESULT,
    output logic O_CONV_START,
    output logic O_CONV_BUSY,
    output logic [ADDR_BITS-1:0] O_CHANNEL_ADDR,
    // Serial pins
    input wire logic I_CS_N,
    input wire logic I_SCK,
    output logic O_SCK,
    output logic O_SCK_OE,
    input wire logic I_SDI,
    output logic O_SDO,
    output logic O_SDO_OE,
    // Status
    output logic O_SCK_INTERNAL,
    output logic O_SLEEP
);
    localparam int FB = adc_serial_pkg::FRAME_BITS;
    localparam int CNTW = $clog2(CONV_CYCLES + 1);
    localparam int BW = $clog2(FB + 1);

    adc_serial_pkg::state_t state_r;
    adc_serial_pkg::state_t state_nxt;

    logic [CNTW-1:0] conv_cnt_r;
    logic [FB-1:0] shift_r;
    logic [ADDR_BITS-1:0] addr_shift_r;
    logic [ADDR_BITS-1:0] addr_r;
    logic [BW-1:0] rise_cnt_r;
    logic [BW-1:0] fall_cnt_r;
    logic sck_int_r;
    logic cs_n_q_r;
    logic sck_q_r;
    logic sdo_r;
    logic init_r;
    logic started_r;

    logic cs_fall;
    logic cs_rise;
    logic ext_rise;
    logic ext_fall;
    logic int_rise;
    logic int_fall;
    logic int_level;
    logic sck_rise;
    logic sck_fall;
    logic conv_done;
    logic div_run;
    logic frame_end;
    logic abort;

    // ------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------
    // Select and clock levels one cycle back
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            cs_n_q_r <= 1'b1;
        end else if (I_CE) begin
            cs_n_q_r <= I_CS_N;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sck_q_r <= 1'b0;
        end else if (I_CE) begin
            sck_q_r <= I_SCK;
        end
    end

    assign cs_fall = cs_n_q_r && !I_CS_N;
    assign cs_rise = !cs_n_q_r && I_CS_N;
    assign ext_rise = !sck_q_r && I_SCK;
    assign ext_fall = sck_q_r && !I_SCK;

    // ------------------------------------------------------------
    // Clock mode selection
    // ------------------------------------------------------------
    // Caught on the first enabled cycle after reset release
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            init_r <= 1'b1;
        end else if (I_CE) begin
            init_r <= 1'b0;
        end
    end

    // Mode taken from the pin level at those moments
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sck_int_r <= 1'b1;
        end else if (I_CE) begin
            if (init_r || cs_fall) begin
                sck_int_r <= I_SCK;
            end
        end
    end

    // ------------------------------------------------------------
    // Internal serial clock
    // ------------------------------------------------------------
    assign div_run = sck_int_r && !I_CS_N && (state_r == adc_serial_pkg::ST_DATA);

    adc_sclk_divider #(
        .DIV(adc_serial_pkg::SCLK_DIV)
    ) u_div (
        .i_clk(I_CLK_SYS),
        .i_reset_n(I_RESET_N),
        .i_ce(I_CE),
        .i_run(div_run),
        .i_conv_tick(I_CONV_TICK),
        .o_rise(int_rise),
        .o_fall(int_fall),
        .o_level(int_level)
    );

    // Internal mode: leaving sleep after one low cycle is the first rise, later edges come from the divider
    // The pin is the inverse of the divider level, so a level fall is a pin rise
    assign sck_rise = sck_int_r ? (int_fall || (state_r == adc_serial_pkg::ST_SLEEP && !I_CS_N && !cs_n_q_r))
                                : ext_rise;
    assign sck_fall = sck_int_r ? int_rise : ext_fall;

    // Clock pin: high during conversion, low while sleeping with select low, divided clock in data state
    // Released until the first mode sample after reset, so that sample sees the bus level
    assign O_SCK_OE = sck_int_r && !init_r;
    always_comb begin
        case (state_r)
            adc_serial_pkg::ST_CONVERT: O_SCK = 1'b1;
            // Stays high until select is seen low, so a select fall still samples high
            adc_serial_pkg::ST_SLEEP: O_SCK = cs_n_q_r;
            adc_serial_pkg::ST_DATA: O_SCK = !int_level;
            default: O_SCK = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Conversion timer
    // ------------------------------------------------------------
    assign conv_done = (state_r == adc_serial_pkg::ST_CONVERT) && I_CONV_TICK &&
                       (conv_cnt_r == CNTW'(CONV_CYCLES - 1));

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            conv_cnt_r <= '0;
        end else if (I_CE) begin
            if (state_r != adc_serial_pkg::ST_CONVERT) begin
                conv_cnt_r <= '0;
            end else if (I_CONV_TICK) begin
                conv_cnt_r <= conv_done ? '0 : conv_cnt_r + CNTW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    // A frame ends on its nineteenth falling edge
    assign frame_end = (fall_cnt_r == BW'(FB - 1)) && sck_fall;
    assign abort = (state_r == adc_serial_pkg::ST_DATA) && cs_rise;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            adc_serial_pkg::ST_CONVERT: begin
                if (conv_done) begin
                    state_nxt = adc_serial_pkg::ST_SLEEP;
                end
            end
            adc_serial_pkg::ST_SLEEP: begin
                if (!I_CS_N && sck_rise) begin
                    state_nxt = adc_serial_pkg::ST_DATA;
                end
            end
            adc_serial_pkg::ST_DATA: begin
                if (abort || frame_end) begin
                    state_nxt = adc_serial_pkg::ST_CONVERT;
                end
            end
            default: state_nxt = adc_serial_pkg::ST_CONVERT;
        endcase
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_r <= adc_serial_pkg::ST_CONVERT;
        end else if (I_CE) begin
            state_r <= state_nxt;
        end
    end

    assign O_CONV_START = I_CE && (state_r == adc_serial_pkg::ST_DATA) &&
                          (state_nxt == adc_serial_pkg::ST_CONVERT);
    assign O_CONV_BUSY = (state_r == adc_serial_pkg::ST_CONVERT);
    assign O_SLEEP = (state_r == adc_serial_pkg::ST_SLEEP);

    // ------------------------------------------------------------
    // Edge counters within a frame
    // ------------------------------------------------------------
    // Rising edges saturate at the frame length
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rise_cnt_r <= '0;
        end else if (I_CE) begin
            if (state_r != adc_serial_pkg::ST_DATA && state_nxt != adc_serial_pkg::ST_DATA) begin
                rise_cnt_r <= '0;
            end else if (sck_rise && rise_cnt_r != BW'(FB)) begin
                rise_cnt_r <= rise_cnt_r + BW'(1);
            end
        end
    end

    // Falling edges count only inside the data state
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            fall_cnt_r <= '0;
        end else if (I_CE) begin
            if (state_r != adc_serial_pkg::ST_DATA) begin
                fall_cnt_r <= '0;
            end else if (sck_fall) begin
                fall_cnt_r <= fall_cnt_r + BW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Output shift register
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            shift_r <= '0;
        end else if (I_CE) begin
            if (conv_done) begin
                shift_r[adc_serial_pkg::EOC_POS] <= 1'b0;
                shift_r[adc_serial_pkg::FILLER_POS] <= 1'b0;
                shift_r[adc_serial_pkg::POLARITY_POS] <= I_POLARITY_BIT;
                shift_r[adc_serial_pkg::RESULT_BITS-1:0] <= I_RESULT;
            end else if (state_r == adc_serial_pkg::ST_DATA && sck_fall) begin
                shift_r <= {shift_r[FB-2:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Serial data output
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sdo_r <= 1'b1;
        end else if (I_CE) begin
            case (state_nxt)
                adc_serial_pkg::ST_CONVERT: sdo_r <= 1'b1;
                adc_serial_pkg::ST_SLEEP: sdo_r <= 1'b0;
                adc_serial_pkg::ST_DATA: begin
                    if (state_r == adc_serial_pkg::ST_DATA && sck_fall) begin
                        sdo_r <= shift_r[FB-2];
                    end else if (state_r != adc_serial_pkg::ST_DATA) begin
                        sdo_r <= shift_r[FB-1];
                    end
                end
                default: sdo_r <= 1'b1;
            endcase
        end
    end

    assign O_SDO = sdo_r;
    assign O_SDO_OE = !I_CS_N;

    // ------------------------------------------------------------
    // Channel address capture
    // ------------------------------------------------------------
    // First address bits shift in on rising edges while selected
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            addr_shift_r <= adc_serial_pkg::ADDR_RESET;
        end else if (I_CE) begin
            if (state_r != adc_serial_pkg::ST_CONVERT && !I_CS_N
                && sck_rise && rise_cnt_r < BW'(ADDR_BITS)) begin
                addr_shift_r <= {addr_shift_r[ADDR_BITS-2:0], I_SDI};
            end
        end
    end

    // Marks a frame that has begun taking address bits
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            started_r <= 1'b0;
        end else if (I_CE) begin
            if (state_r == adc_serial_pkg::ST_CONVERT || I_CS_N) begin
                started_r <= 1'b0;
            end else if (sck_rise && rise_cnt_r < BW'(ADDR_BITS)) begin
                started_r <= 1'b1;
            end
        end
    end

    // Commit only once the last address bit is in; an earlier abort leaves addr_r alone
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            addr_r <= adc_serial_pkg::ADDR_RESET;
        end else if (I_CE) begin
            if (started_r && rise_cnt_r == BW'(ADDR_BITS) && !I_CS_N
                && state_r == adc_serial_pkg::ST_DATA && sck_fall && fall_cnt_r == BW'(ADDR_BITS - 1)) begin
                addr_r <= addr_shift_r;
            end
        end
    end

    assign O_CHANNEL_ADDR = addr_r;
    assign O_SCK_INTERNAL = sck_int_r;

endmodule : adc_serial_readout_interface

//--- logic/adc_serial_pkg.sv
// Shared constants for the converter serial readout interface
package adc_serial_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 19;
    localparam int RESULT_BITS = 16;
    localparam int EOC_POS = 18;
    localparam int FILLER_POS = 17;
    localparam int POLARITY_POS = 16;
    localparam int ADDR_BITS = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SCLK_DIV = 8;
    localparam int SCLK_HALF = SCLK_DIV / 2;
    localparam int CONV_CYCLES = 20510;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RESET = 8'h00;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CONVERT,
        ST_SLEEP,
        ST_DATA
    } state_t;

endpackage : adc_serial_pkg

//--- logic/adc_sclk_divider.sv
// Internal serial clock generator: divides the conversion clock tick
module adc_sclk_divider #(
    parameter int DIV = adc_serial_pkg::SCLK_DIV
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    // Control
    input wire logic i_run,
    input wire logic i_conv_tick,
    // Edges
    output logic o_rise,
    output logic o_fall,
    output logic o_level
);
    localparam int HALF = DIV / 2;
    localparam int CW = $clog2(HALF) + 1;

    logic [CW-1:0] cnt_r;
    logic level_r;
    logic hit;

    assign hit = i_run && i_conv_tick && (cnt_r == CW'(HALF - 1));
    assign o_rise = hit && !level_r;
    assign o_fall = hit && level_r;
    assign o_level = level_r;

    // Half-period counter in conversion clock ticks
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_r <= '0;
        end else if (i_ce) begin
            if (!i_run) begin
                cnt_r <= '0;
            end else if (i_conv_tick) begin
                cnt_r <= hit ? '0 : cnt_r + CW'(1);
            end
        end
    end

    // Clock level, starts low each frame
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            level_r <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                level_r <= 1'b0;
            end else if (hit) begin
                level_r <= !level_r;
            end
        end
    end

endmodule : adc_sclk_divider

//--- verification/adc_serial_readout_interface_assertions.sv
// Port-level checker for the converter serial readout interface
module adc_serial_readout_interface_assertions #(
    parameter int ADDR_BITS = 8
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    // Converter side
    input wire logic O_CONV_START,
    input wire logic O_CONV_BUSY,
    input wire logic [ADDR_BITS-1:0] O_CHANNEL_ADDR,
    // Serial pins and status
    input wire logic I_CS_N,
    input wire logic I_SCK,
    input wire logic O_SCK,
    input wire logic O_SCK_OE,
    input wire logic O_SDO,
    input wire logic O_SDO_OE,
    input wire logic O_SCK_INTERNAL,
    input wire logic O_SLEEP
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RESET_N);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_cs_fall_steady;
        $fell(I_CS_N) && $stable(I_SCK) ##1 $stable(I_SCK);
    endsequence
    sequence s_data_abort;
        !O_CONV_BUSY && !O_SLEEP && $rose(I_CS_N);
    endsequence
    chk_sdo_release: assert property (I_CS_N |-> !O_SDO_OE)
        else $error("data out driven with select high");
    chk_sdo_drive: assert property (!I_CS_N |-> O_SDO_OE)
        else $error("data out not driven with select low");
    chk_busy_flag: assert property ($past(O_CONV_BUSY) && O_CONV_BUSY && O_SDO_OE |-> O_SDO)
        else $error("flag low while converting");
    chk_sleep_flag: assert property ($past(O_SLEEP) && O_SLEEP && O_SDO_OE |-> !O_SDO)
        else $error("flag high while asleep");
    chk_addr_hold: assert property (!$stable(O_CHANNEL_ADDR) |-> !$past(I_CS_N) && !$past(O_CONV_BUSY))
        else $error("channel changed outside a transfer");
    chk_start_busy: assert property (O_CONV_START |=> O_CONV_BUSY)
        else $error("start pulse without conversion");
    chk_abort_start: assert property (s_data_abort |-> ##[0:2] O_CONV_START)
        else $error("abort did not start a conversion");
    chk_sck_mode: assert property (O_SCK_OE == (O_SCK_INTERNAL && $past(I_RESET_N)))
        else $error("clock drive does not follow mode");
    chk_sck_busy: assert property (O_SCK_OE && O_CONV_BUSY && $past(O_CONV_BUSY) |-> O_SCK)
        else $error("internal clock low while converting");
    chk_mode_pick: assert property (s_cs_fall_steady |=> O_SCK_INTERNAL == $past(I_SCK))
        else $error("clock mode not taken from clock level");
    chk_sleep_hold: assert property (O_SLEEP && I_CS_N && $past(I_CS_N) |=> O_SLEEP)
        else $error("sleep left with select high");
endmodule : adc_serial_readout_interface_assertions

bind adc_serial_readout_interface adc_serial_readout_interface_assertions #(.ADDR_BITS(ADDR_BITS)) i_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .O_CONV_START(O_CONV_START),
    .O_CONV_BUSY(O_CONV_BUSY), .O_CHANNEL_ADDR(O_CHANNEL_ADDR), .I_CS_N(I_CS_N),
    .I_SCK(I_SCK), .O_SCK(O_SCK), .O_SCK_OE(O_SCK_OE), .O_SDO(O_SDO), .O_SDO_OE(O_SDO_OE),
    .O_SCK_INTERNAL(O_SCK_INTERNAL), .O_SLEEP(O_SLEEP)
);

//--- verification/adc_host_model.sv
// Host controller model driving select, serial clock and data in
module adc_host_model (
    // Clock
    input wire logic i_clk,
    // Serial pins
    input wire logic i_sdo,
    input wire logic i_sck,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_sck_oe,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_sck_oe = 1'b1;
        o_sdi = 1'b0;
    end
    task automatic wait_sdo(input logic v);
        for (int w = 0; w < 3000 && i_sdo !== v; w++) @(negedge i_clk);
    endtask : wait_sdo
    task automatic cs_high;
        @(negedge i_clk) o_cs_n = 1'b1;
    endtask : cs_high
    // Host-clocked frame; raises select after nbits rises when nbits < 19
    task automatic frame(input logic [7:0] addr, input int nbits, output logic [18:0] frm);
        frm = '0;
        @(negedge i_clk) o_cs_n = 1'b0;
        repeat (2) @(negedge i_clk);
        wait_sdo(1'b0);
        for (int i = 0; i < 19; i++) begin
            if (i == nbits) begin
                o_cs_n = 1'b1;
                return;
            end
            o_sdi = (i < 8) ? addr[7 - i] : ~o_sdi;
            repeat (4) @(negedge i_clk);
            frm[18 - i] = i_sdo;
            o_sck = 1'b1;
            repeat (4) @(negedge i_clk);
            o_sck = 1'b0;
        end
        o_sdi = ~o_sdi;
    endtask : frame
    // Releases the clock line and captures a device-clocked frame
    task automatic rx_int(output logic [18:0] frm, output int per);
        logic p;
        int n;
        frm = '0;
        per = 0;
        o_sck_oe = 1'b0;
        @(negedge i_clk) o_cs_n = 1'b0;
        wait_sdo(1'b1);
        wait_sdo(1'b0);
        p = i_sck;
        n = 0;
        for (int w = 0; w < 3000 && n < 19; w++) begin
            @(negedge i_clk);
            if (i_sck && !p) begin
                frm[18 - n] = i_sdo;
                if (n == 1 || n == 2) per = (n == 1) ? w : w - per;
                n++;
            end
            p = i_sck;
        end
    endtask : rx_int
endmodule : adc_host_model

//--- verification/testbench.sv
// Self-checking bench for the converter serial readout interface
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 20;
    logic clk, rst_n, tick, pol, cs_n, h_sck, h_sck_oe, sdi, sck_w;
    logic [15:0] res;
    logic conv_start, conv_busy, sck_o, sck_oe, sdo, sdo_oe, sck_int, sleep;
    logic [7:0] addr;
    logic [18:0] f;
    int per;
    int fails = 0;
    int tests_run = 0;
    // Clock line with pull-up when nobody drives it
    assign sck_w = sck_oe ? sck_o : (h_sck_oe ? h_sck : 1'b1);
    adc_serial_readout_interface #(.CONV_CYCLES(CONV)) i_adc_serial_readout_interface (
        .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CE(1'b1), .I_CONV_TICK(tick),
        .I_POLARITY_BIT(pol), .I_RESULT(res), .O_CONV_START(conv_start), .O_CONV_BUSY(conv_busy),
        .O_CHANNEL_ADDR(addr), .I_CS_N(cs_n), .I_SCK(sck_w), .O_SCK(sck_o), .O_SCK_OE(sck_oe),
        .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(sdo_oe), .O_SCK_INTERNAL(sck_int), .O_SLEEP(sleep)
    );
    adc_host_model i_adc_host_model (
        .i_clk(clk), .i_sdo(sdo), .i_sck(sck_w), .o_cs_n(cs_n), .o_sck(h_sck),
        .o_sck_oe(h_sck_oe), .o_sdi(sdi)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial tick = 1'b0;
    always @(negedge clk) tick <= ~tick;
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        repeat (2) @(negedge clk);
        check({15'h0000, sck_int, sck_oe, sdo_oe, conv_busy}, 19'h00001);
    endtask : t_reset
    task automatic t_frame;
        i_adc_host_model.frame(8'h3C, 19, f);
        check(f, {3'h1, 16'hA5C3});
        repeat (3) @(negedge clk);
        check({17'h00000, conv_busy, sdo}, 19'h00003);
        check({11'h000, addr}, 19'h0003C);
    endtask : t_frame
    task automatic t_abort;
        res = 16'hF234;
        pol = 1'b0;
        i_adc_host_model.frame(8'h81, 5, f);
        repeat (3) @(negedge clk);
        check({14'h0000, f[18:14]}, 19'h00003);
        check({10'h000, addr, conv_busy}, {10'h000, 8'h3C, 1'b1});
    endtask : t_abort
    task automatic t_sleep;
        res = 16'h0F0F;
        pol = 1'b1;
        for (int w = 0; w < 300 && sleep !== 1'b1; w++) @(negedge clk);
        res = 16'hFFFF;
        pol = 1'b0;
        repeat (20) @(negedge clk);
        check({18'h00000, sleep}, 19'h00001);
        i_adc_host_model.frame(8'h5A, 19, f);
        check(f, {3'h1, 16'h0F0F});
        check({11'h000, addr}, 19'h0005A);
        i_adc_host_model.cs_high();
    endtask : t_sleep
    task automatic t_internal;
        res = 16'h8001;
        pol = 1'b0;
        i_adc_host_model.rx_int(f, per);
        check(f, {3'h0, 16'h8001});
        check({7'h00, sck_int, 11'(per)}, {8'h01, 11'(2 * adc_serial_pkg::SCLK_DIV)});
        res = 16'h7FFE;
        pol = 1'b1;
        i_adc_host_model.rx_int(f, per);
        check(f, {3'h1, 16'h7FFE});
    endtask : t_internal
    initial begin
        rst_n = 1'b0;
        pol = 1'b1;
        res = 16'hA5C3;
        repeat (2) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        t_reset();
        t_frame();
        t_abort();
        t_sleep();
        t_internal();
        final_report();
    end
    // Whole run needs about 1200 cycles; allow several times that
    initial begin
        #100us;
        fails++;
        final_report();
    end
endmodule : testbench
